// *** dv/dm_sva.sv ***
/* Checker for the data memory unit.
   Assumes binding to the unit's top module ports. */
`timescale 1ns/1ps
module dm_sva (
  input wire logic clk, // Core clock.
  input wire logic reset_n, // Synchronous reset.
  input wire logic req_valid, // Request strobe.
  input wire logic wdt_timeout, // Watchdog time-out.
  input wire logic sleep_exec, // Sleep executed.
  input wire logic [13:0] pm_rdata, // Program word.
  input wire logic busy_r, // Access in progress.
  input wire logic done_r, // Access finished.
  input wire logic [7:0] rdata_r, // Read data.
  input wire dm_pkg::status_t status_r, // Status image.
  input wire logic [7:0] bank_sel_r, // Bank select.
  input wire logic pm_rd_r, // Program read strobe.
  input wire logic [14:0] pm_addr_r, // Program address.
  input wire logic ext_sel_r // Ext register access.
);
  // Low byte of the program word, the only part a data read may see.
  logic [7:0] pm_lo;
  assign pm_lo = pm_rdata[7:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_acc; req_valid && !busy_r |=> busy_r; endproperty
  a_acc: assert property (p_acc) else $error("request not taken");
  property p_ext; ext_sel_r |=> done_r && !busy_r; endproperty
  a_ext: assert property (p_ext) else $error("ext access slow");
  property p_pm_len; pm_rd_r |=> busy_r && !done_r ##1 done_r; endproperty
  a_pm_len: assert property (p_pm_len) else $error("pm length");
  property p_pm_wrap; pm_rd_r |-> pm_addr_r[14:13] == 2'h0; endproperty
  a_pm_wrap: assert property (p_pm_wrap) else $error("no wrap");
  property p_pm_lo; pm_rd_r |-> ##2 rdata_r == $past(pm_lo); endproperty
  a_pm_lo: assert property (p_pm_lo) else $error("pm byte");
  property p_stat_hi; status_r.unused == 3'h0; endproperty
  a_stat_hi: assert property (p_stat_hi) else $error("status hi");
  property p_bank_hi; bank_sel_r[7:5] == 3'h0; endproperty
  a_bank_hi: assert property (p_bank_hi) else $error("bank hi");
  property p_tout; wdt_timeout |=> !status_r.timeout_flag_n; endproperty
  a_tout: assert property (p_tout) else $error("timeout flag");
  property p_sleep;
    sleep_exec && !wdt_timeout |=> !status_r.powerdown_flag_n;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flag");
endmodule : dm_sva
////////////////////////////////////////////////////////////////////////////
bind banked_data_memory_status dm_sva dm_sva_i (.clk(clk),
  .reset_n(reset_n), .req_valid(req_valid), .wdt_timeout(wdt_timeout),
  .sleep_exec(sleep_exec), .pm_rdata(pm_rdata), .busy_r(busy_r),
  .done_r(done_r), .rdata_r(rdata_r), .status_r(status_r),
  .bank_sel_r(bank_sel_r), .pm_rd_r(pm_rd_r), .pm_addr_r(pm_addr_r),
  .ext_sel_r(ext_sel_r));

// *** dv/pm_model.sv ***
/* Program memory and peripheral register model.
   Assumes the unit's strobes are one-cycle pulses on clk. */
`timescale 1ns/1ps
module pm_model (
  input wire logic clk, // Core clock.
  input wire logic pm_rd_r, // Program read strobe.
  input wire logic [14:0] pm_addr_r, // Word address.
  input wire logic ext_sel_r, // Ext register access.
  input wire logic [6:0] ext_addr_r, // Ext offset.
  output logic [13:0] pm_rdata = 14'h0000, // Program word.
  output logic [7:0] ext_rdata // Ext read data.
);
  // High address bits fold into the word, so a missed wrap shows.
  // Outside the hold cycle the word toggles rather than lingering.
  always_ff @(posedge clk)
    pm_rdata <= pm_rd_r ?
      {pm_addr_r[5:0], pm_addr_r[7:0] ^ {pm_addr_r[14:8], 1'b1}} : ~pm_rdata;
  // Peripheral bytes follow their offset; idle value is all ones.
  assign ext_rdata = ext_sel_r ? {1'b0, ext_addr_r} ^ 8'h5A : 8'hFF;
endmodule : pm_model

// *** dv/testbench.sv ***
/* Self-checking bench for the data memory unit.
   Assumes the design and dm_cfg.svh are compiled alongside. */
`timescale 1ns/1ps
`include "dm_cfg.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module testbench;
  logic clk, reset_n, por_reset, req_valid, wdt_clear, sleep_exec;
  logic wdt_timeout, busy_r, done_r, pm_rd_r, ext_sel_r, ext_we_r;
  dm_pkg::access_req_t req;
  dm_pkg::status_t status_r;
  logic [13:0] pm_rdata;
  logic [14:0] pm_addr_r;
  logic [7:0] ext_rdata, rdata_r, bank_sel_r, ext_wdata_r, rd;
  logic [6:0] ext_addr_r;
  int fail_count = 0, tests_run = 0, lat;
  dm_pkg::alu_op_t t_op[6] = '{dm_pkg::ALU_ADD, dm_pkg::ALU_SUB,
    dm_pkg::ALU_SUB, dm_pkg::ALU_LOGIC, dm_pkg::ALU_ROT_RIGHT,
    dm_pkg::ALU_ROT_LEFT};
  logic [7:0] t_a[6] = '{8'hF8, 8'h05, 8'h03, 8'h00, 8'h01, 8'h7F};
  logic [7:0] t_b[6] = '{8'h08, 8'h03, 8'h05, 8'h00, 8'h00, 8'h00};
  logic [7:0] t_m[6] = '{8'hFF, 8'hFF, 8'hFF, 8'h04, 8'h01, 8'h01};
  logic [7:0] t_e[6] = '{8'h1F, 8'h1B, 8'h18, 8'h04, 8'h01, 8'h00};
  banked_data_memory_status banked_data_memory_status_i (.clk(clk),
    .reset_n(reset_n), .por_reset(por_reset), .req_valid(req_valid),
    .req(req), .wdt_clear(wdt_clear), .sleep_exec(sleep_exec),
    .wdt_timeout(wdt_timeout), .pm_rdata(pm_rdata), .ext_rdata(ext_rdata),
    .busy_r(busy_r), .done_r(done_r), .rdata_r(rdata_r),
    .status_r(status_r), .bank_sel_r(bank_sel_r), .pm_rd_r(pm_rd_r),
    .pm_addr_r(pm_addr_r), .ext_sel_r(ext_sel_r), .ext_we_r(ext_we_r),
    .ext_addr_r(ext_addr_r), .ext_wdata_r(ext_wdata_r));
  pm_model pm_model_i (.clk(clk), .pm_rd_r(pm_rd_r), .pm_addr_r(pm_addr_r),
    .ext_sel_r(ext_sel_r), .ext_addr_r(ext_addr_r), .pm_rdata(pm_rdata),
    .ext_rdata(ext_rdata));
  //////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (fail_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  // One access; lat counts cycles from raising req_valid to the done pulse.
  task automatic acc(input logic w, input logic [6:0] o, input logic [7:0] d,
    input dm_pkg::alu_op_t op, input logic [7:0] a, input logic [7:0] b);
    @(posedge clk); #5;
    req_valid = 1'b1;
    req = {w, o, d, op, a, b};
    @(posedge clk); #5;
    req_valid = 1'b0;
    if (o == 7'h0C)
      `CHK({ext_sel_r, ext_we_r, ext_wdata_r}, {1'b1, w, d})
    lat = 1;
    while (done_r !== 1'b1 && lat < 9)
    begin
      @(posedge clk); #5;
      lat++;
    end
    `CHK(done_r, 1'b1)
    rd = rdata_r;
  endtask : acc
  task automatic wr(input logic [6:0] o, input logic [7:0] d);
    acc(1'b1, o, d, dm_pkg::ALU_NONE, 8'h00, 8'h00);
  endtask : wr
  task automatic rdc(input logic [6:0] o, input logic [7:0] e);
    acc(1'b0, o, 8'h00, dm_pkg::ALU_NONE, 8'h00, 8'h00);
    `CHK(rd, e)
  endtask : rdc
  // Events are one-cycle pulses: clear, sleep, time-out.
  task automatic ev(input logic [2:0] k);
    @(posedge clk); #5;
    {wdt_clear, sleep_exec, wdt_timeout} = k;
    @(posedge clk); #5;
    {wdt_clear, sleep_exec, wdt_timeout} = 3'h0;
  endtask : ev
  task automatic rst(input logic por);
    reset_n = 1'b0;
    por_reset = por;
    repeat (8) @(posedge clk);
    #5;
    reset_n = 1'b1;
  endtask : rst
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    #100000;
    fail_count++;
    close_out();
  end
  initial
  begin
    {req_valid, wdt_clear, sleep_exec, wdt_timeout} = 4'h0;
    req = '0;
    rst(1'b1);
    `CHK(status_r, 8'h18)
    wr(`OFF_BANK_SEL, 8'hFF);
    `CHK(bank_sel_r, 8'h1F)
    wr(`OFF_BANK_SEL, 8'h03);
    wr(7'h20, 8'hA5);
    wr(7'h70, 8'h3C);
    wr(`OFF_BANK_SEL, 8'h04);
    wr(7'h20, 8'h5A);
    rdc(7'h70, 8'h3C);
    wr(`OFF_BANK_SEL, 8'h03);
    rdc(7'h20, 8'hA5);
    `CHK(lat, 2)
    rdc(`OFF_STATUS, 8'h18);
    rdc(7'h0C, 8'h56);
    wr(7'h0C, 8'h6B);
    rdc(`OFF_DATA_PORT0, 8'h00);
    wr(`OFF_STATUS, 8'hFF);
    `CHK(status_r, 8'h1F)
    wr(`OFF_STATUS, 8'h00);
    `CHK(status_r, 8'h18)
    for (int i = 0; i < 6; i++)
    begin
      acc(1'b1, `OFF_STATUS, 8'h00, t_op[i], t_a[i], t_b[i]);
      `CHK(status_r & t_m[i], t_e[i])
    end
    wr(`OFF_PTR1_LO, 8'h34);
    wr(`OFF_PTR1_HI, 8'hA1);
    rdc(`OFF_DATA_PORT1, 8'h37);
    `CHK(lat, 3)
    wr(`OFF_DATA_PORT1, 8'h99);
    rdc(`OFF_DATA_PORT1, 8'h37);
    ev(3'b010);
    `CHK(status_r[4:3], 2'b10)
    ev(3'b001);
    `CHK(status_r[4:3], 2'b00)
    ev(3'b100);
    `CHK(status_r[4:3], 2'b11)
    acc(1'b0, 7'h20, 8'h00, dm_pkg::ALU_ROT_RIGHT, 8'h01, 8'h00);
    rst(1'b0);
    `CHK(status_r.carry, 1'b1)
    close_out();
  end
endmodule : testbench

// *** hw/banked_data_memory_status.sv ***
/*
 * Banked data memory and arithmetic status unit of an 8-bit core.
 * Decodes 32 banks of 128 bytes, holds status, pointers and bank
 * select, and reads program memory as data through the pointers.
 * Assumes the execution unit, program memory and peripheral registers
 * share clk; all strobes come from that domain.
 */
// Function
// RL1: pointer high bit 7 selects program memory
// RL2: program read returns low eight bits only
// RL3: writes to program memory are dropped
// RL4: program memory access takes one extra cycle
// RL5: thirty-two banks of 128 bytes each
// RL6: direct accesses use current bank select value
// RL7: unimplemented locations read as zero
// RL8: core registers at 00h-0Bh in every bank
// RL9: 0Ch-1Fh reach peripheral registers of bank; only the offset goes out on ext_addr_r, with no bank
// RL10: 20h-6Fh reach banked general RAM
// RL11: 70h-7Fh reach one shared common RAM
// RL12: flag-updating instruction overrides explicit flag write
// RL13: time-out and power-down flags ignore writes
// RL14: status bits 7-5 read as zero
// RL15: time-out flag set, cleared by watchdog timeout
// RL16: power-down flag set, cleared by sleep
// RL17: zero flag follows zero result
// RL18: digit carry is carry out of bit 3
// RL19: carry is carry out of bit 7
// RL20: subtract adds two's complement, borrow inverted
// RL21: rotates load carry from low or high bit
// RL22: power-on resets flags; other resets keep arithmetic
// RL23: software should alter status with flag-neutral moves
// RL24: bank select holds five bits, upper zero
// RL25: program addresses wrap within implemented space
`timescale 1ns/1ps
`include "dm_cfg.svh"

module banked_data_memory_status (
  input wire logic clk,                    // Core clock, 20 MHz.
  input wire logic reset_n,                // Synchronous reset.
  input wire logic por_reset,              // Reset is power-on/brown-out.
  input wire logic req_valid,              // Access request strobe.
  input wire dm_pkg::access_req_t req,     // Access request fields.
  input wire logic wdt_clear,              // Watchdog clear executed.
  input wire logic sleep_exec,             // Sleep executed.
  input wire logic wdt_timeout,            // Watchdog timed out.
  input wire logic [13:0] pm_rdata,        // Program word, cycle after rd.
  input wire logic [7:0] ext_rdata,        // Data of selected ext register.
  output logic busy_r,                     // Access in progress.
  output logic done_r,                     // Access finished, one cycle.
  output logic [7:0] rdata_r,              // Read data with done_r.
  output dm_pkg::status_t status_r,        // Status register image.
  output logic [7:0] bank_sel_r,           // Bank select read value.
  output logic pm_rd_r,                    // Program memory read strobe.
  output logic [14:0] pm_addr_r,           // Program word address.
  output logic ext_sel_r,                  // Ext register selected.
  output logic ext_we_r,                   // Ext register write.
  output logic [6:0] ext_addr_r,           // Ext register bank offset.
  output logic [7:0] ext_wdata_r           // Ext register write data.
);

  //////////////////////////////////////////////////////////////////////
  // Declarations
  //////////////////////////////////////////////////////////////////////

  dm_pkg::seq_state_t state_r, state_nxt;  // Access sequencer.
  dm_pkg::region_t cap_region_r, cap_region_nxt; // Region of access.
  logic [6:0] cap_off_r, cap_off_nxt;      // Offset of access.
  logic busy_nxt;                          // Next busy.
  logic done_nxt;                          // Next done.
  logic [7:0] rdata_nxt;                   // Next read data.
  logic pm_rd_nxt;                         // Next program read strobe.
  logic [14:0] pm_addr_nxt;                // Next program address.
  logic ext_sel_nxt;                       // Next ext select.
  logic ext_we_nxt;                        // Next ext write.
  logic [6:0] ext_addr_nxt;                // Next ext offset.
  logic [7:0] ext_wdata_nxt;               // Next ext write data.
  dm_pkg::status_t status_nxt;             // Next status.
  logic [7:0] ptr0_lo_r, ptr0_lo_nxt;      // Pointer 0 low byte.
  logic [7:0] ptr0_hi_r, ptr0_hi_nxt;      // Pointer 0 high byte.
  logic [7:0] ptr1_lo_r, ptr1_lo_nxt;      // Pointer 1 low byte.
  logic [7:0] ptr1_hi_r, ptr1_hi_nxt;      // Pointer 1 high byte.
  logic [4:0] bsr_r, bsr_nxt;              // Bank select, five bits.
  logic accept;                            // Request taken this cycle.
  logic indirect;                          // Offset is a data port.
  logic [15:0] ptr;                        // Pointer used by the port.
  logic prog;                              // Access targets program.
  logic [4:0] eff_bank;                    // Resolved bank.
  logic [6:0] eff_off;                     // Resolved offset.
  dm_pkg::region_t region;                 // Resolved region.
  logic is_ext;                            // Offset served outside.
  logic ram_we;                            // Backing store write.
  logic [`RAM_AW-1:0] ram_addr;            // Backing store index.
  logic [7:0] ram_q;                       // Backing store read data.
  logic upd_z, upd_dc, upd_c;              // Flag update enables.
  logic new_z, new_dc, new_c;              // Computed flag values.
  logic [8:0] sum;                         // Full adder result.
  logic [4:0] nib;                         // Low nibble adder result.
  logic [7:0] addend;                      // Second operand, maybe negated.
  logic cin;                               // Carry into the adder.
  logic core_wr;                           // Write to a local core reg.

  //////////////////////////////////////////////////////////////////////
  // Address resolution
  //////////////////////////////////////////////////////////////////////

  // Turn the request offset into bank, offset and region. The data
  // ports re-enter the map through their pointer, so a port pointing
  // at a port finds core space there and reads back zero.
  always_comb
  begin
    accept = req_valid && (state_r == dm_pkg::ST_IDLE);
    indirect = (req.offset == `OFF_DATA_PORT0) ||
               (req.offset == `OFF_DATA_PORT1);
    if (req.offset == `OFF_DATA_PORT1)
    begin
      ptr = {ptr1_hi_r, ptr1_lo_r};
    end
    else
    begin
      ptr = {ptr0_hi_r, ptr0_lo_r};
    end
    prog = indirect && ptr[`PTR_PROG_BIT];            // see RL1
    if (indirect)
    begin
      eff_bank = ptr[`PTR_BANK_HI:`PTR_BANK_LO];
      eff_off = ptr[`PTR_OFF_HI:0];
    end
    else
    begin
      eff_bank = bsr_r;                               // see RL6
      eff_off = req.offset;
    end
    // Region split of every 128-byte bank.
    if (eff_off <= `CORE_LAST)
    begin
      region = dm_pkg::REG_CORE;                      // see RL8
    end
    else if (eff_off <= `PERIPH_LAST)
    begin
      region = dm_pkg::REG_PERIPH;                    // see RL9
    end
    else if (eff_off <= `GRAM_LAST)
    begin
      region = dm_pkg::REG_GRAM;                      // see RL10
    end
    else
    begin
      region = dm_pkg::REG_COMMON;                    // see RL11
    end
    // Core registers not held here are served by the execution unit.
    is_ext = (region == dm_pkg::REG_PERIPH) ||
             ((region == dm_pkg::REG_CORE) &&
              (eff_off != `OFF_DATA_PORT0) &&
              (eff_off != `OFF_DATA_PORT1) &&
              (eff_off != `OFF_STATUS) &&
              !((eff_off >= `OFF_PTR0_LO) && (eff_off <= `OFF_BANK_SEL)));
    // Banked RAM is indexed by bank and offset; common RAM always
    // lands in bank zero so all banks share the same sixteen bytes.
    if (region == dm_pkg::REG_COMMON)
    begin
      ram_addr = {`BANK_ZERO, eff_off};               // see RL11
    end
    else
    begin
      ram_addr = {eff_bank, eff_off};                 // see RL5
    end
    ram_we = accept && req.write && !prog &&          // see RL3
             ((region == dm_pkg::REG_GRAM) ||
              (region == dm_pkg::REG_COMMON));
    core_wr = accept && req.write && !prog &&
              (region == dm_pkg::REG_CORE);
  end

  //////////////////////////////////////////////////////////////////////
  // Flag computation
  //////////////////////////////////////////////////////////////////////

  // Subtraction reuses the adder on the two's complement of the second
  // operand, which is why carries read as inverted borrows.
  always_comb
  begin
    if (req.alu_op == dm_pkg::ALU_SUB)
    begin
      addend = ~req.opb;                              // see RL20
      cin = 1'b1;
    end
    else
    begin
      addend = req.opb;
      cin = 1'b0;
    end
    sum = {1'b0, req.opa} + {1'b0, addend} + {8'h00, cin};
    nib = {1'b0, req.opa[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
    upd_z = 1'b0;
    upd_dc = 1'b0;
    upd_c = 1'b0;
    new_z = 1'b0;
    new_dc = 1'b0;
    new_c = 1'b0;
    case (req.alu_op)
      dm_pkg::ALU_ADD, dm_pkg::ALU_SUB:
      begin
        upd_z = 1'b1;
        upd_dc = 1'b1;
        upd_c = 1'b1;
        new_z = (sum[7:0] == 8'h00);                  // see RL17
        new_dc = nib[4];                              // see RL18
        new_c = sum[8];                               // see RL19
      end
      dm_pkg::ALU_LOGIC:
      begin
        upd_z = 1'b1;
        new_z = (req.opa == 8'h00);                   // see RL17
      end
      dm_pkg::ALU_ROT_RIGHT:
      begin
        upd_c = 1'b1;
        new_c = req.opa[0];                           // see RL21
      end
      dm_pkg::ALU_ROT_LEFT:
      begin
        upd_c = 1'b1;
        new_c = req.opa[7];                           // see RL21
      end
      default:
      begin
        upd_z = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Core registers
  //////////////////////////////////////////////////////////////////////

  // Next values of status, pointers and bank select.
  always_comb
  begin
    status_nxt = status_r;
    ptr0_lo_nxt = ptr0_lo_r;
    ptr0_hi_nxt = ptr0_hi_r;
    ptr1_lo_nxt = ptr1_lo_r;
    ptr1_hi_nxt = ptr1_hi_r;
    bsr_nxt = bsr_r;
    if (core_wr)
    begin
      case (eff_off)
        `OFF_STATUS:
        begin
          // The explicit write is lost whenever the instruction itself
          // moves any arithmetic flag; reset flags are never written.
          if (req.alu_op == dm_pkg::ALU_NONE)         // see RL12, RL13
          begin
            status_nxt.zero = req.wdata[2];
            status_nxt.digit_carry_flag = req.wdata[1];
            status_nxt.carry = req.wdata[0];
          end
        end
        `OFF_PTR0_LO: ptr0_lo_nxt = req.wdata;
        `OFF_PTR0_HI: ptr0_hi_nxt = req.wdata;
        `OFF_PTR1_LO: ptr1_lo_nxt = req.wdata;
        `OFF_PTR1_HI: ptr1_hi_nxt = req.wdata;
        `OFF_BANK_SEL: bsr_nxt = req.wdata[4:0];      // see RL24
        default: bsr_nxt = bsr_r;
      endcase
    end
    if (accept)
    begin
      if (upd_z)
      begin
        status_nxt.zero = new_z;                      // see RL12
      end
      if (upd_dc)
      begin
        status_nxt.digit_carry_flag = new_dc;
      end
      if (upd_c)
      begin
        status_nxt.carry = new_c;
      end
    end
    // Hardware events; a time-out in the same cycle as a clear wins.
    if (wdt_clear)
    begin
      status_nxt.timeout_flag_n = 1'b1;               // see RL15, RL16
      status_nxt.powerdown_flag_n = 1'b1;
    end
    if (sleep_exec)
    begin
      status_nxt.timeout_flag_n = 1'b1;               // see RL15
      status_nxt.powerdown_flag_n = 1'b0;             // see RL16
    end
    if (wdt_timeout)
    begin
      status_nxt.timeout_flag_n = 1'b0;               // see RL15
    end
    status_nxt.unused = `BANK_PAD;                    // see RL14
  end

  // Only power-on and brown-out resets touch the status flags; other
  // resets leave them for software to inspect the cause.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      if (por_reset)
      begin
        status_r <= `STATUS_POR;                      // see RL22
      end
      ptr0_lo_r <= 8'h00;
      ptr0_hi_r <= 8'h00;
      ptr1_lo_r <= 8'h00;
      ptr1_hi_r <= 8'h00;
      bsr_r <= `BANK_ZERO;
      bank_sel_r <= 8'h00;
    end
    else
    begin
      status_r <= status_nxt;
      ptr0_lo_r <= ptr0_lo_nxt;
      ptr0_hi_r <= ptr0_hi_nxt;
      ptr1_lo_r <= ptr1_lo_nxt;
      ptr1_hi_r <= ptr1_hi_nxt;
      bsr_r <= bsr_nxt;
      bank_sel_r <= {`BANK_PAD, bsr_nxt};             // see RL24
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Access sequencer
  //////////////////////////////////////////////////////////////////////

  // Data accesses finish one cycle after acceptance; program reads
  // wait a further cycle for the registered program memory.
  always_comb
  begin
    state_nxt = state_r;
    cap_region_nxt = cap_region_r;
    cap_off_nxt = cap_off_r;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    pm_rd_nxt = 1'b0;
    pm_addr_nxt = pm_addr_r;
    ext_sel_nxt = 1'b0;
    ext_we_nxt = 1'b0;
    ext_addr_nxt = ext_addr_r;
    ext_wdata_nxt = ext_wdata_r;
    case (state_r)
      dm_pkg::ST_IDLE:
      begin
        if (accept)
        begin
          cap_region_nxt = region;
          cap_off_nxt = eff_off;
          if (prog && !req.write)
          begin
            state_nxt = dm_pkg::ST_PROG;              // see RL4
            pm_rd_nxt = 1'b1;
            pm_addr_nxt = ptr[14:0] & `PM_ADDR_MASK;  // see RL25
          end
          else
          begin
            state_nxt = dm_pkg::ST_DATA;
            ext_sel_nxt = is_ext && !prog;
            ext_we_nxt = is_ext && !prog && req.write;
            ext_addr_nxt = eff_off;
            ext_wdata_nxt = req.wdata;
          end
        end
      end
      dm_pkg::ST_DATA:
      begin
        state_nxt = dm_pkg::ST_IDLE;
        done_nxt = 1'b1;
        case (cap_region_r)
          dm_pkg::REG_GRAM, dm_pkg::REG_COMMON: rdata_nxt = ram_q;
          dm_pkg::REG_PERIPH: rdata_nxt = ext_rdata;
          default:
          begin
            case (cap_off_r)
              `OFF_STATUS: rdata_nxt = status_r;
              `OFF_PTR0_LO: rdata_nxt = ptr0_lo_r;
              `OFF_PTR0_HI: rdata_nxt = ptr0_hi_r;
              `OFF_PTR1_LO: rdata_nxt = ptr1_lo_r;
              `OFF_PTR1_HI: rdata_nxt = ptr1_hi_r;
              `OFF_BANK_SEL: rdata_nxt = bank_sel_r;
              `OFF_DATA_PORT0, `OFF_DATA_PORT1:
                rdata_nxt = 8'h00;                    // see RL7
              default: rdata_nxt = ext_rdata;
            endcase
          end
        endcase
      end
      dm_pkg::ST_PROG:
      begin
        state_nxt = dm_pkg::ST_PDATA;
      end
      dm_pkg::ST_PDATA:
      begin
        state_nxt = dm_pkg::ST_IDLE;
        done_nxt = 1'b1;
        rdata_nxt = pm_rdata[7:0];                    // see RL2
      end
      default:
      begin
        state_nxt = dm_pkg::ST_IDLE;
      end
    endcase
    busy_nxt = (state_nxt != dm_pkg::ST_IDLE);
  end

  // Sequencer registers.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_r <= dm_pkg::ST_IDLE;
      cap_region_r <= dm_pkg::REG_CORE;
      cap_off_r <= 7'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= 8'h00;
      pm_rd_r <= 1'b0;
      pm_addr_r <= 15'h0000;
      ext_sel_r <= 1'b0;
      ext_we_r <= 1'b0;
      ext_addr_r <= 7'h00;
      ext_wdata_r <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      cap_region_r <= cap_region_nxt;
      cap_off_r <= cap_off_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
      pm_rd_r <= pm_rd_nxt;
      pm_addr_r <= pm_addr_nxt;
      ext_sel_r <= ext_sel_nxt;
      ext_we_r <= ext_we_nxt;
      ext_addr_r <= ext_addr_nxt;
      ext_wdata_r <= ext_wdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Backing store
  //////////////////////////////////////////////////////////////////////

  // General and common RAM of all banks in one array.
  ram_store u_ram (
    .clk(clk),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(req.wdata),
    .rdata_r(ram_q)
  );

endmodule : banked_data_memory_status

// *** hw/dm_cfg.svh ***
/*
 * Address map, field positions and reset values of the banked data
 * memory and status unit. Included by the package and by every design
 * file that decodes an offset; it defines macros only.
 */
`ifndef DM_CFG_SVH
`define DM_CFG_SVH

// Core register offsets, present at the bottom of every bank.
`define OFF_DATA_PORT0 7'h00
`define OFF_DATA_PORT1 7'h01
`define OFF_STATUS 7'h03
`define OFF_PTR0_LO 7'h04
`define OFF_PTR0_HI 7'h05
`define OFF_PTR1_LO 7'h06
`define OFF_PTR1_HI 7'h07
`define OFF_BANK_SEL 7'h08

// Last offset of each region inside a 128-byte bank.
`define CORE_LAST 7'h0B
`define PERIPH_LAST 7'h1F
`define GRAM_LAST 7'h6F

// Indirect pointer layout: program select bit, bank field, offset field.
`define PTR_PROG_BIT 15
`define PTR_BANK_HI 11
`define PTR_BANK_LO 7
`define PTR_OFF_HI 6

// Program memory: 8K words implemented, higher addresses wrap.
`define PM_ADDR_MASK 15'h1FFF

// Bank select and backing store geometry.
`define BANK_ZERO 5'h00
`define BANK_PAD 3'h0
`define RAM_AW 12
`define RAM_DEPTH 4096

// Status reset value after power-on or brown-out: both reset flags set.
`define STATUS_POR 8'h18

`endif

// *** hw/dm_pkg.sv ***
/*
 * Types shared by the data memory unit, its checker and its bench.
 * Assumes dm_cfg.svh is on the include path.
 */
`include "dm_cfg.svh"

package dm_pkg;

  // Sequencer states; program fetches spend one state more.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DATA = 2'b01,
    ST_PROG = 2'b10,
    ST_PDATA = 2'b11
  } seq_state_t;

  // Flag-affecting operation carried with each access.
  typedef enum logic [2:0] {
    ALU_NONE = 3'b000,
    ALU_ADD = 3'b001,
    ALU_SUB = 3'b010,
    ALU_LOGIC = 3'b011,
    ALU_ROT_RIGHT = 3'b100,
    ALU_ROT_LEFT = 3'b101
  } alu_op_t;

  // Memory region selected by a bank offset.
  typedef enum logic [1:0] {
    REG_CORE = 2'b00,
    REG_PERIPH = 2'b01,
    REG_GRAM = 2'b10,
    REG_COMMON = 2'b11
  } region_t;

  // One access request from the execution unit.
  typedef struct packed {
    logic write;        // Store wdata at the target.
    logic [6:0] offset; // Bank offset of the file operand.
    logic [7:0] wdata;  // Data to store.
    alu_op_t alu_op;    // Flag effect of the instruction.
    logic [7:0] opa;    // Source operand, or result for logic ops.
    logic [7:0] opb;    // Second operand for add and subtract.
  } access_req_t;

  // Arithmetic and reset status register image, bit 7 down to bit 0.
  typedef struct packed {
    logic [2:0] unused; // Unimplemented, always zero.
    logic timeout_flag_n;
    logic powerdown_flag_n;
    logic zero;
    logic digit_carry_flag;
    logic carry;
  } status_t;

endpackage : dm_pkg

// *** hw/ram_store.sv ***
/*
 * Byte-wide storage for general RAM of all banks and common RAM.
 * Read data leave through a register, one cycle after the address.
 * Assumes a single clock and a write strobe from the same domain.
 */
`timescale 1ns/1ps
`include "dm_cfg.svh"

module ram_store (
  input wire logic clk,                   // Core clock.
  input wire logic we,                    // Write strobe.
  input wire logic [`RAM_AW-1:0] addr,    // Byte index.
  input wire logic [7:0] wdata,           // Write data.
  output logic [7:0] rdata_r              // Registered read data.
);

  // The array itself; no reset so it maps onto block memory.
  logic [7:0] mem [0:`RAM_DEPTH-1];

  // Read first: a read on the writing edge returns the old contents.
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata_r <= mem[addr];
  end

endmodule : ram_store
